// ---- slgc_pkg.sv ----
// Package with register map, field positions, reset values and codes for the lock/gain register bank.
package slgc_pkg;
    localparam int unsigned SLGC_AW = 10;
    localparam logic [9:0] SLGC_REF_CFG_ADDR = 10'h20e;
    localparam logic [9:0] SLGC_LOCK_SETUP_ADDR = 10'h214;
    localparam logic [9:0] SLGC_SETTLE_ADDR = 10'h218;
    localparam logic [9:0] SLGC_CAL_LO_ADDR = 10'h21c;
    localparam logic [9:0] SLGC_CAL_HI_ADDR = 10'h21d;
    localparam logic [9:0] SLGC_BAND_DIV_ADDR = 10'h21e;
    localparam logic [9:0] SLGC_PBIAS_ADDR = 10'h22b;
    localparam logic [9:0] SLGC_PUMP_ADDR = 10'h22e;
    localparam logic [9:0] SLGC_BLEED_ADDR = 10'h22f;
    localparam logic [9:0] SLGC_LOCK_STAT_ADDR = 10'h24d;
    localparam logic [9:0] SLGC_TEST_SEL_ADDR = 10'h24e;
    localparam logic [9:0] SLGC_ATTEN_ADDR = 10'h300;
    localparam logic [9:0] SLGC_APIN_ADDR = 10'h301;
    localparam logic [9:0] SLGC_MUTE_ADDR = 10'h103;
    // Reset values.
    localparam logic [7:0] SLGC_REF_CFG_RST = 8'h04;
    localparam logic [7:0] SLGC_LOCK_SETUP_RST = 8'h48;
    localparam logic [7:0] SLGC_SETTLE_RST = 8'h1f;
    localparam logic [7:0] SLGC_CAL_LO_RST = 8'h19;
    localparam logic [7:0] SLGC_CAL_HI_RST = 8'h00;
    localparam logic [7:0] SLGC_BAND_DIV_RST = 8'h10;
    localparam logic [7:0] SLGC_PBIAS_RST = 8'h09;
    localparam logic [7:0] SLGC_PUMP_RST = 8'h0e;
    localparam logic [7:0] SLGC_BLEED_RST = 8'h08;
    localparam logic [7:0] SLGC_TEST_SEL_RST = 8'h00;
    localparam logic [7:0] SLGC_ATTEN_RST = 8'h00;
    localparam logic [7:0] SLGC_APIN_RST = 8'h00;
    localparam logic [7:0] SLGC_MUTE_RST = 8'h01;
    // Writable-bit masks; other bits read back their fixed reset value.
    localparam logic [7:0] SLGC_REF_CFG_WM = 8'h0f;
    localparam logic [7:0] SLGC_SETTLE_WM = 8'h1f;
    localparam logic [7:0] SLGC_CAL_HI_WM = 8'h03;
    localparam logic [7:0] SLGC_PBIAS_WM = 8'h03;
    localparam logic [7:0] SLGC_PUMP_WM = 8'h0f;
    localparam logic [7:0] SLGC_ATTEN_WM = 8'h1f;
    localparam logic [7:0] SLGC_APIN_WM = 8'h0f;
    localparam logic [7:0] SLGC_MUTE_WM = 8'h01;
    localparam logic [7:0] SLGC_FULL_WM = 8'hff;
    // Field positions.
    localparam int unsigned SLGC_DOUBLER_BIT = 3;
    localparam int unsigned SLGC_HALVE_BIT = 0;
    localparam int unsigned SLGC_LCOUNT_LSB = 3;
    localparam int unsigned SLGC_APIN_DIR_BIT = 3;
    localparam int unsigned SLGC_CNT_W = 14;
    localparam logic [13:0] SLGC_CNT_BASE = 14'h0400;
    // Test output codes.
    localparam logic [3:0] SLGC_TO_LOW = 4'h0;
    localparam logic [3:0] SLGC_TO_LOCK = 4'h1;
    localparam logic [3:0] SLGC_TO_RDIV = 4'h4;
    localparam logic [3:0] SLGC_TO_NDIV = 4'h5;
    localparam logic [3:0] SLGC_TO_HIGH = 4'he;
    // Analog mux codes.
    localparam logic [2:0] SLGC_AMUX_DET = 3'h0;
    localparam logic [2:0] SLGC_AMUX_TEMP = 3'h6;
    localparam logic [2:0] SLGC_AMUX_PIN = 3'h7;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } slgc_req_type;
    typedef struct packed {
        logic doubler_on;
        logic ref_freq_halve_on;
        logic [1:0] lock_window_bias_sel;
        logic [4:0] attenuation_step_sel;
        logic [1:0] prescaler_bias_sel;
        logic [3:0] pump_current_sel;
        logic [7:0] bleed_current_sel;
        logic [4:0] synth_settle_limit;
        logic [9:0] osc_cal_limit;
        logic [7:0] osc_band_clock_divider;
    } slgc_ctrl_type;
endpackage

// ---- slgc_regs.sv ----
// Register bank, lock counter, test output mux and analog routing of the synthesizer.
`timescale 1ns/100ps
`default_nettype none
module slgc_regs
    import slgc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Register port from the serial front end
    input wire slgc_req_type req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // Reference clock domain events, asynchronous to mclk_in
    input wire logic ref_clk_in,
    input wire logic pfd_good_in,
    input wire logic rcnt_half_in,
    input wire logic ncnt_half_in,
    // Analog side
    output var slgc_ctrl_type ctrl_out,
    output logic test_pin_out,
    output logic mute_out,
    output logic analog_pin_oe_out,
    output logic [2:0] analog_mux_source_out,
    output logic analog_mux_pin_ok_out
);
    logic [7:0] ref_cfg_r, lock_setup_r, settle_r, cal_lo_r, cal_hi_r, band_div_r;
    logic [7:0] pbias_r, pump_r, bleed_r, test_sel_r, atten_r, apin_r, mute_r;
    logic lock_r;
    logic [SLGC_CNT_W-1:0] good_cnt_r;
    logic [SLGC_CNT_W-1:0] good_cnt_nxt;
    logic [2:0] rclk_s_r;
    logic [1:0] good_s_r;
    logic [1:0] rh_s_r, nh_s_r;

    // Write strobes and masked write data.
    function automatic logic [7:0] wmask(input logic [7:0] cur, input logic [7:0] wd,
                                          input logic [7:0] m);
        wmask = (cur & ~m) | (wd & m);
    endfunction

    wire wr_ref = req_in.wr && (req_in.addr == SLGC_REF_CFG_ADDR);
    wire wr_lock = req_in.wr && (req_in.addr == SLGC_LOCK_SETUP_ADDR);
    wire wr_settle = req_in.wr && (req_in.addr == SLGC_SETTLE_ADDR);
    wire wr_cal_lo = req_in.wr && (req_in.addr == SLGC_CAL_LO_ADDR);
    wire wr_cal_hi = req_in.wr && (req_in.addr == SLGC_CAL_HI_ADDR);
    wire wr_band = req_in.wr && (req_in.addr == SLGC_BAND_DIV_ADDR);
    wire wr_pbias = req_in.wr && (req_in.addr == SLGC_PBIAS_ADDR);
    wire wr_pump = req_in.wr && (req_in.addr == SLGC_PUMP_ADDR);
    wire wr_bleed = req_in.wr && (req_in.addr == SLGC_BLEED_ADDR);
    wire wr_test = req_in.wr && (req_in.addr == SLGC_TEST_SEL_ADDR);
    wire wr_atten = req_in.wr && (req_in.addr == SLGC_ATTEN_ADDR);
    wire wr_apin = req_in.wr && (req_in.addr == SLGC_APIN_ADDR);
    wire wr_mute = req_in.wr && (req_in.addr == SLGC_MUTE_ADDR);

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_cfg_r <= SLGC_REF_CFG_RST;
            lock_setup_r <= SLGC_LOCK_SETUP_RST;
            settle_r <= SLGC_SETTLE_RST;
            cal_lo_r <= SLGC_CAL_LO_RST;
            cal_hi_r <= SLGC_CAL_HI_RST;
            band_div_r <= SLGC_BAND_DIV_RST;
            pbias_r <= SLGC_PBIAS_RST;
            pump_r <= SLGC_PUMP_RST;
            bleed_r <= SLGC_BLEED_RST;
            test_sel_r <= SLGC_TEST_SEL_RST;
            atten_r <= SLGC_ATTEN_RST;
            apin_r <= SLGC_APIN_RST;
            mute_r <= SLGC_MUTE_RST;
        end else begin
            if (wr_ref) ref_cfg_r <= wmask(ref_cfg_r, req_in.wdata, SLGC_REF_CFG_WM);
            if (wr_lock) lock_setup_r <= req_in.wdata;
            if (wr_settle) settle_r <= wmask(settle_r, req_in.wdata, SLGC_SETTLE_WM);
            if (wr_cal_lo) cal_lo_r <= req_in.wdata;
            if (wr_cal_hi) cal_hi_r <= wmask(cal_hi_r, req_in.wdata, SLGC_CAL_HI_WM);
            if (wr_band) band_div_r <= wmask(band_div_r, req_in.wdata, SLGC_FULL_WM);
            if (wr_pbias) pbias_r <= wmask(pbias_r, req_in.wdata, SLGC_PBIAS_WM);
            if (wr_pump) pump_r <= wmask(pump_r, req_in.wdata, SLGC_PUMP_WM);
            if (wr_bleed) bleed_r <= req_in.wdata;
            if (wr_test) test_sel_r <= req_in.wdata;
            if (wr_atten) atten_r <= wmask(atten_r, req_in.wdata, SLGC_ATTEN_WM);
            if (wr_apin) apin_r <= wmask(apin_r, req_in.wdata, SLGC_APIN_WM);
            if (wr_mute) mute_r <= wmask(mute_r, req_in.wdata, SLGC_MUTE_WM);
        end
    end

    // Read mux; unmapped addresses read as zero.
    logic [7:0] rd_mux;
    always_comb begin
        case (req_in.addr)
            SLGC_REF_CFG_ADDR: rd_mux = ref_cfg_r;
            SLGC_LOCK_SETUP_ADDR: rd_mux = lock_setup_r;
            SLGC_SETTLE_ADDR: rd_mux = settle_r;
            SLGC_CAL_LO_ADDR: rd_mux = cal_lo_r;
            SLGC_CAL_HI_ADDR: rd_mux = cal_hi_r;
            SLGC_BAND_DIV_ADDR: rd_mux = band_div_r;
            SLGC_PBIAS_ADDR: rd_mux = pbias_r;
            SLGC_PUMP_ADDR: rd_mux = pump_r;
            SLGC_BLEED_ADDR: rd_mux = bleed_r;
            SLGC_LOCK_STAT_ADDR: rd_mux = {7'h00, lock_r};
            SLGC_TEST_SEL_ADDR: rd_mux = test_sel_r;
            SLGC_ATTEN_ADDR: rd_mux = atten_r;
            SLGC_APIN_ADDR: rd_mux = apin_r;
            SLGC_MUTE_ADDR: rd_mux = mute_r;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
            if (req_in.rd) rdata_out <= rd_mux;
        end
    end

    // Synchronisers for reference-domain signals; only later stages are read.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rclk_s_r <= 3'h0;
            good_s_r <= 2'h0;
            rh_s_r <= 2'h0;
            nh_s_r <= 2'h0;
        end else begin
            rclk_s_r <= {rclk_s_r[1:0], ref_clk_in};
            good_s_r <= {good_s_r[0], pfd_good_in};
            rh_s_r <= {rh_s_r[0], rcnt_half_in};
            nh_s_r <= {nh_s_r[0], ncnt_half_in};
        end
    end

    // One phase-detector cycle per rising edge of the synchronised reference.
    wire pfd_tick = rclk_s_r[1] && !rclk_s_r[2];
    wire pfd_good = good_s_r[1];
    wire [2:0] lcount = lock_setup_r[SLGC_LCOUNT_LSB +: 3];
    // Codes above 011 saturate to the longest count.
    wire [1:0] lshift = lcount[2] ? 2'h3 : lcount[1:0];
    wire [SLGC_CNT_W-1:0] lock_target = SLGC_CNT_BASE << lshift;

    always_comb begin
        good_cnt_nxt = good_cnt_r;
        if (pfd_tick) begin
            if (!pfd_good) good_cnt_nxt = '0;
            else if (good_cnt_r < lock_target) good_cnt_nxt = good_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            good_cnt_r <= '0;
            lock_r <= 1'b0;
        end else begin
            good_cnt_r <= good_cnt_nxt;
            lock_r <= (good_cnt_nxt >= lock_target);
        end
    end

    // Test output source selection.
    logic test_nxt;
    always_comb begin
        case (test_sel_r[3:0])
            SLGC_TO_LOW: test_nxt = 1'b0;
            SLGC_TO_LOCK: test_nxt = lock_r;
            SLGC_TO_RDIV: test_nxt = rh_s_r[1];
            SLGC_TO_NDIV: test_nxt = nh_s_r[1];
            SLGC_TO_HIGH: test_nxt = 1'b1;
            default: test_nxt = 1'b0;
        endcase
    end

    wire pin_dir_in = apin_r[SLGC_APIN_DIR_BIT];
    wire [2:0] amux_src = apin_r[2:0];
    // The pin source is only honoured while the pin is configured as input.
    wire amux_ok = (amux_src != SLGC_AMUX_PIN) || pin_dir_in;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_out <= '0;
            test_pin_out <= 1'b0;
            mute_out <= 1'b1;
            analog_pin_oe_out <= 1'b1;
            analog_mux_source_out <= SLGC_AMUX_DET;
            analog_mux_pin_ok_out <= 1'b1;
        end else begin
            ctrl_out.doubler_on <= ref_cfg_r[SLGC_DOUBLER_BIT];
            ctrl_out.ref_freq_halve_on <= ref_cfg_r[SLGC_HALVE_BIT];
            ctrl_out.lock_window_bias_sel <= lock_setup_r[7:6];
            ctrl_out.attenuation_step_sel <= atten_r[4:0];
            ctrl_out.prescaler_bias_sel <= pbias_r[1:0];
            ctrl_out.pump_current_sel <= pump_r[3:0];
            ctrl_out.bleed_current_sel <= bleed_r;
            ctrl_out.synth_settle_limit <= settle_r[4:0];
            ctrl_out.osc_cal_limit <= {cal_hi_r[1:0], cal_lo_r};
            ctrl_out.osc_band_clock_divider <= band_div_r;
            test_pin_out <= test_nxt;
            mute_out <= mute_r[0] && !lock_r;
            analog_pin_oe_out <= !pin_dir_in;
            analog_mux_source_out <= amux_ok ? amux_src : SLGC_AMUX_DET;
            analog_mux_pin_ok_out <= amux_ok;
        end
    end
endmodule // slgc_regs
`default_nettype wire

// ---- slgc_regs_checker.sv ----
// Port assertions for the lock/gain register bank.
`timescale 1ns/100ps
`default_nettype none
module slgc_regs_checker
    import slgc_pkg::*;
(
    // Clock, reset and register port
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire slgc_req_type req_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    // Analog side
    input wire slgc_ctrl_type ctrl_out,
    input wire logic analog_pin_oe_out,
    input wire logic [2:0] analog_mux_source_out,
    input wire logic analog_mux_pin_ok_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // One write to an address that is not repeated on the next cycle.
    sequence s_lone_wr(a);
        req_in.wr && req_in.addr == a ##1 !(req_in.wr && req_in.addr == a);
    endsequence
    chk_read_strobe: assert property (rvalid_out == $past(req_in.rd))
        else $error("read answer strobe wrong");
    chk_lock_upper: assert property
        (req_in.rd && req_in.addr == SLGC_LOCK_STAT_ADDR |=> rdata_out[7:1] == 7'h00)
        else $error("lock status upper bits not zero");
    chk_atten_follow: assert property
        (s_lone_wr(SLGC_ATTEN_ADDR) |=>
        ctrl_out.attenuation_step_sel == $past(req_in.wdata[4:0], 2))
        else $error("attenuation code not applied");
    chk_ref_bits: assert property (s_lone_wr(SLGC_REF_CFG_ADDR) |=>
        {ctrl_out.doubler_on, ctrl_out.ref_freq_halve_on} ==
        {$past(req_in.wdata[3], 2), $past(req_in.wdata[0], 2)})
        else $error("reference doubling or halving not applied");
    chk_settle_follow: assert property
        (s_lone_wr(SLGC_SETTLE_ADDR) |=>
        ctrl_out.synth_settle_limit == $past(req_in.wdata[4:0], 2))
        else $error("settle limit not applied");
    chk_cal_low: assert property
        (s_lone_wr(SLGC_CAL_LO_ADDR) |=> ctrl_out.osc_cal_limit[7:0] == $past(req_in.wdata, 2))
        else $error("calibration limit low byte not applied");
    chk_band_follow: assert property
        (s_lone_wr(SLGC_BAND_DIV_ADDR) |-> ##1
        ctrl_out.osc_band_clock_divider == $past(req_in.wdata, 2))
        else $error("band divider not applied");
    chk_src_guard: assert property
        (analog_mux_source_out == SLGC_AMUX_PIN |-> !analog_pin_oe_out)
        else $error("pin selected as mux source while driven");
    chk_pin_ok: assert property
        (!analog_mux_pin_ok_out |-> analog_mux_source_out == SLGC_AMUX_DET && analog_pin_oe_out)
        else $error("refused pin source not forced to detector");
endmodule // slgc_regs_checker
bind slgc_regs slgc_regs_checker u_chk (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_in(req_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .ctrl_out(ctrl_out),
    .analog_pin_oe_out(analog_pin_oe_out), .analog_mux_source_out(analog_mux_source_out),
    .analog_mux_pin_ok_out(analog_mux_pin_ok_out));
`default_nettype wire

// ---- test_synth_lock_gain_control_regs.sv ----
// Self-checking testbench of the lock/gain register bank.
`timescale 1ns/100ps
`default_nettype none
module test_synth_lock_gain_control_regs import slgc_pkg::*;;
    logic mclk_in = 1'b0, nrst_in = 1'b0, ref_clk_in = 1'b0, pfd_good_in = 1'b0;
    logic rcnt_half_in = 1'b1, ncnt_half_in = 1'b0;
    slgc_req_type req_in = '0;
    logic [7:0] rdata_out;
    slgc_ctrl_type ctrl_out;
    logic rvalid_out, test_pin_out, mute_out, analog_pin_oe_out, analog_mux_pin_ok_out;
    logic [2:0] analog_mux_source_out;
    int failures = 0, n_checks = 0;
    logic [9:0] at [14] = '{SLGC_REF_CFG_ADDR, SLGC_LOCK_SETUP_ADDR, SLGC_SETTLE_ADDR,
        SLGC_CAL_LO_ADDR, SLGC_CAL_HI_ADDR, SLGC_BAND_DIV_ADDR, SLGC_PBIAS_ADDR, SLGC_PUMP_ADDR,
        SLGC_BLEED_ADDR, SLGC_LOCK_STAT_ADDR, SLGC_TEST_SEL_ADDR, SLGC_ATTEN_ADDR,
        SLGC_APIN_ADDR, SLGC_MUTE_ADDR};
    logic [7:0] rt [14] = '{SLGC_REF_CFG_RST, SLGC_LOCK_SETUP_RST, SLGC_SETTLE_RST,
        SLGC_CAL_LO_RST, SLGC_CAL_HI_RST, SLGC_BAND_DIV_RST, SLGC_PBIAS_RST, SLGC_PUMP_RST,
        SLGC_BLEED_RST, 8'h00, SLGC_TEST_SEL_RST, SLGC_ATTEN_RST, SLGC_APIN_RST, SLGC_MUTE_RST};
    logic [7:0] wt [14] = '{SLGC_REF_CFG_WM, SLGC_FULL_WM, SLGC_SETTLE_WM, SLGC_FULL_WM,
        SLGC_CAL_HI_WM, SLGC_FULL_WM, SLGC_PBIAS_WM, SLGC_PUMP_WM, SLGC_FULL_WM, 8'h00,
        SLGC_FULL_WM, SLGC_ATTEN_WM, SLGC_APIN_WM, SLGC_MUTE_WM};
    slgc_regs dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_in(req_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .ref_clk_in(ref_clk_in), .pfd_good_in(pfd_good_in),
        .rcnt_half_in(rcnt_half_in), .ncnt_half_in(ncnt_half_in), .ctrl_out(ctrl_out),
        .test_pin_out(test_pin_out), .mute_out(mute_out), .analog_pin_oe_out(analog_pin_oe_out),
        .analog_mux_source_out(analog_mux_source_out),
        .analog_mux_pin_ok_out(analog_mux_pin_ok_out));
    always #5 mclk_in = ~mclk_in;
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_in);
        req_in.wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(negedge mclk_in);
        req_in.rd = 1'b1;
        req_in.addr = a;
        @(negedge mclk_in);
        req_in.rd = 1'b0;
        check("rvalid_out", 10'h001, 10'(rvalid_out));
        check("rdata_out", 10'(exp), 10'(rdata_out));
    endtask
    // One reference cycle; the window flag is set up a cycle before the rising edge.
    task automatic tick(input logic good);
        @(negedge mclk_in);
        pfd_good_in = good;
        @(negedge mclk_in);
        ref_clk_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        ref_clk_in = 1'b0;
    endtask
    task automatic t_regs;
        logic [7:0] pat [2] = '{8'hff, 8'h5a};
        for (int i = 0; i < 14; i++) rd(at[i], rt[i]);
        rd(10'h3ff, 8'h00);
        foreach (pat[p]) begin
            for (int i = 0; i < 14; i++) wr(at[i], pat[p]);
            wr(10'h3ff, pat[p]);
            for (int i = 0; i < 14; i++) begin
                rd(at[i], (rt[i] & ~wt[i]) | (pat[p] & wt[i]));
            end
        end
        check("attenuation", 10'h01a, 10'(ctrl_out.attenuation_step_sel));
        check("ref", 10'h002, 10'({ctrl_out.doubler_on, ctrl_out.ref_freq_halve_on}));
        check("settle", 10'h01a, 10'(ctrl_out.synth_settle_limit));
        check("cal limit", 10'h25a, ctrl_out.osc_cal_limit);
        check("band div", 10'h05a, 10'(ctrl_out.osc_band_clock_divider));
        // Host setup with the recommended analog codes and the reserved pair kept at 10.
        wr(SLGC_PBIAS_ADDR, 8'h03);
        wr(SLGC_PUMP_ADDR, 8'h0e);
        wr(SLGC_BLEED_ADDR, 8'h27);
        wr(SLGC_REF_CFG_ADDR, 8'h05);
        rd(SLGC_REF_CFG_ADDR, 8'h05);
        check("prescaler bias", 10'h003, 10'(ctrl_out.prescaler_bias_sel));
        check("pump current", 10'h00e, 10'(ctrl_out.pump_current_sel));
        check("bleed current", 10'h027, 10'(ctrl_out.bleed_current_sel));
        check("ref", 10'h001, 10'({ctrl_out.doubler_on, ctrl_out.ref_freq_halve_on}));
        check("lock bias", 10'h001, 10'(ctrl_out.lock_window_bias_sel));
        $display("register test done");
    endtask
    task automatic apin(input logic [7:0] d, input logic [2:0] src, input logic oe);
        wr(SLGC_APIN_ADDR, d);
        repeat (2) @(negedge mclk_in);
        check("analog_mux_source_out", 10'(src), 10'(analog_mux_source_out));
        check("analog_pin_oe_out", 10'(oe), 10'(analog_pin_oe_out));
        check("analog_mux_pin_ok_out", 10'(d[3] || d[2:0] != 3'h7), 10'(analog_mux_pin_ok_out));
    endtask
    task automatic t_pin;
        logic [3:0] code [4] = '{SLGC_TO_LOW, SLGC_TO_HIGH, SLGC_TO_RDIV, SLGC_TO_NDIV};
        logic [3:0] exp = 4'h6;
        apin(8'h07, SLGC_AMUX_DET, 1'b1);
        apin(8'h0f, SLGC_AMUX_PIN, 1'b0);
        apin(8'h06, SLGC_AMUX_TEMP, 1'b1);
        foreach (code[i]) begin
            wr(SLGC_TEST_SEL_ADDR, 8'(code[i]));
            repeat (6) @(negedge mclk_in);
            check("test_pin_out", 10'(exp[i]), 10'(test_pin_out));
        end
        ncnt_half_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        check("test_pin_out", 10'h001, 10'(test_pin_out));
        $display("routing test done");
    endtask
    task automatic t_lock;
        wr(SLGC_LOCK_SETUP_ADDR, 8'h40);
        wr(SLGC_MUTE_ADDR, 8'h01);
        wr(SLGC_TEST_SEL_ADDR, 8'(SLGC_TO_LOCK));
        tick(1'b0);
        repeat (1023) tick(1'b1);
        rd(SLGC_LOCK_STAT_ADDR, 8'h00);
        tick(1'b1);
        rd(SLGC_LOCK_STAT_ADDR, 8'h01);
        check("mute_out", 10'h000, 10'(mute_out));
        check("test_pin_out", 10'h001, 10'(test_pin_out));
        tick(1'b0);
        rd(SLGC_LOCK_STAT_ADDR, 8'h00);
        check("mute_out", 10'h001, 10'(mute_out));
        wr(SLGC_MUTE_ADDR, 8'h00);
        repeat (3) @(negedge mclk_in);
        check("mute_out", 10'h000, 10'(mute_out));
        wr(SLGC_LOCK_SETUP_ADDR, 8'h48);
        repeat (2047) tick(1'b1);
        rd(SLGC_LOCK_STAT_ADDR, 8'h00);
        tick(1'b1);
        rd(SLGC_LOCK_STAT_ADDR, 8'h01);
        tick(1'b0);
        rd(SLGC_LOCK_STAT_ADDR, 8'h00);
        check("mute_out", 10'h000, 10'(mute_out));
        $display("lock test done");
    endtask
    initial begin
        #300_000;
        failures++;
        finish_test;
    end
    initial begin
        repeat (20) @(negedge mclk_in);
        nrst_in = 1'b1;
        t_regs;
        t_pin;
        t_lock;
        finish_test;
    end
endmodule // test_synth_lock_gain_control_regs
`default_nettype wire
